// [hw/hpp_host_port.sv]
module hpp_host_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host bus
    input wire logic chip_select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // DMA handshake
    output logic playback_dma_request,
    output logic capture_dma_request,
    input wire logic playback_dma_ack_n,
    input wire logic capture_dma_ack_n,
    // Converter side, one word per sample clock
    input wire logic sample_tick,
    input wire logic [31:0] capture_sample,
    output logic [31:0] playback_sample
);
    logic [7:0] index_reg, next_index_reg;
    logic [7:0] ind_regs [hpp_pkg::NUM_INDIRECT];
    logic [7:0] next_ind_val;
    logic rd_q, wr_q, next_rd_q, next_wr_q;
    logic [7:0] data_q, next_data_q;
    logic [1:0] addr_q, next_addr_q;
    logic [7:0] wr_data_q;
    logic wr_dma_q, next_wr_dma_q;
    logic wr_reg_q, next_wr_reg_q;
    logic rd_drive_q, next_rd_drive_q;
    logic rd_fall, wr_rise, wr_fall;
    logic playback_dma_ack, capture_dma_ack, dma_cycle, reg_cycle;
    logic single_mode, pen, cen, stereo;
    logic [1:0] fmt;
    logic [2:0] bytes_per_sample;
    hpp_pkg::dma_state_t state, next_state;
    logic [31:0] play_hold, next_play_hold;
    logic [31:0] cap_word, next_cap_word;
    logic cap_pending, next_cap_pending;
    logic [31:0] asm_sample;
    logic asm_done;
    logic [2:0] asm_index;
    logic play_byte;
    logic cap_req, play_req, final_fall, play_last;

    assign playback_dma_ack = !playback_dma_ack_n;
    // Capture acknowledge is ignored in single-channel mode; playback acknowledge still counts
    assign capture_dma_ack = !capture_dma_ack_n && !single_mode;
    assign dma_cycle = playback_dma_ack || capture_dma_ack;
    assign reg_cycle = !chip_select_n && !dma_cycle;
    assign rd_fall = !rd_n && rd_q;
    assign wr_rise = wr_n && !wr_q;
    assign wr_fall = !wr_n && wr_q;

    assign single_mode = ind_regs[hpp_pkg::IDX_IFCFG][hpp_pkg::CFG_SDC_BIT];
    assign pen = ind_regs[hpp_pkg::IDX_IFCFG][hpp_pkg::CFG_PEN_BIT];
    assign cen = ind_regs[hpp_pkg::IDX_IFCFG][hpp_pkg::CFG_CEN_BIT];
    assign fmt = ind_regs[hpp_pkg::IDX_FORMAT][hpp_pkg::FMT_MSB:hpp_pkg::FMT_LSB];
    assign stereo = ind_regs[hpp_pkg::IDX_FORMAT][hpp_pkg::FMT_STEREO_BIT];
    // 8-bit linear and both companded modes move one byte per channel
    assign bytes_per_sample = (hpp_pkg::BYTES_ONE << ((fmt == hpp_pkg::FMT_LIN16) ? 1 : 0)) << (stereo ? 1 : 0);

    // Playback path: byte assembly then FIFO, drained at the sample rate
    hpp_stream_if play_in();
    hpp_stream_if play_out();
    hpp_stream_if cap_in();
    hpp_stream_if cap_out();

    // Qualified at the fall, so the last byte still lands after the request drops
    assign play_byte = wr_rise && wr_dma_q;
    hpp_sample_asm u_asm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .byte_strobe(play_byte),
        .byte_in(wr_data_q),
        .bytes_per_sample(bytes_per_sample),
        .abort(1'b0),
        .sample(asm_sample),
        .sample_done(asm_done),
        .byte_index(asm_index)
    );
    assign play_in.valid = asm_done;
    assign play_in.data = (asm_index == hpp_pkg::BYTE_ZERO) ? {24'h00_0000, wr_data_q} :
        (asm_sample & ~(32'h0000_00ff << (asm_index * hpp_pkg::SHIFT_BYTE)))
        | (32'(wr_data_q) << (asm_index * hpp_pkg::SHIFT_BYTE));
    hpp_fifo #(.WIDTH(hpp_pkg::SAMPLE_W), .DEPTH(hpp_pkg::FIFO_DEPTH)) u_play_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_s(play_in),
        .out_s(play_out)
    );
    assign play_out.ready = sample_tick;

    // Capture path: converter words into FIFO, drained by DMA bytes
    assign cap_in.valid = sample_tick && cen;
    assign cap_in.data = capture_sample;
    hpp_fifo #(.WIDTH(hpp_pkg::SAMPLE_W), .DEPTH(hpp_pkg::FIFO_DEPTH)) u_cap_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_s(cap_in),
        .out_s(cap_out)
    );
    // Word loaded only between samples, so a sample is never torn
    assign cap_out.ready = !cap_pending;

    logic [2:0] cap_idx, next_cap_idx;
    logic cap_byte, cap_last;
    assign cap_byte = (state == hpp_pkg::DMA_CAP) && rd_fall && dma_cycle;
    assign cap_last = (cap_idx + hpp_pkg::BYTE_STEP) == bytes_per_sample;

    always_comb begin
        next_rd_q = rd_n;
        next_wr_q = wr_n;
        next_index_reg = index_reg;
        next_data_q = data_q;
        next_play_hold = play_hold;
        next_cap_word = cap_word;
        next_cap_pending = cap_pending;
        next_cap_idx = cap_idx;
        next_ind_val = wr_data_q;
        // Underrun repeats the last good sample instead of a gap
        if (play_out.valid && play_out.ready) begin
            next_play_hold = play_out.data;
        end
        if (!cap_pending && cap_out.valid) begin
            next_cap_word = cap_out.data;
            next_cap_pending = 1'b1;
        end
        if (wr_rise && wr_reg_q && addr_q == hpp_pkg::ADDR_INDEX) begin
            next_index_reg = wr_data_q;
        end
        if (rd_fall && reg_cycle) begin
            unique case (addr)
                hpp_pkg::ADDR_INDEX: next_data_q = index_reg;
                hpp_pkg::ADDR_IDATA: next_data_q = ind_regs[index_reg[hpp_pkg::IDX_W-1:0]];
                hpp_pkg::ADDR_STATUS: next_data_q = {6'h00, cap_pending, play_out.valid};
                hpp_pkg::ADDR_PIO_DATA: next_data_q = cap_word[7:0];
            endcase
        end
        if (cap_byte) begin
            next_data_q = cap_word[cap_idx*hpp_pkg::SHIFT_BYTE +: 8];
            next_cap_idx = cap_last ? hpp_pkg::BYTE_ZERO : cap_idx + hpp_pkg::BYTE_STEP;
            if (cap_last) begin
                next_cap_pending = 1'b0;
            end
        end
    end

    // Write captured on the strobe's rising edge; qualifiers latched at its fall
    always_comb begin
        next_addr_q = addr_q;
        next_wr_dma_q = wr_dma_q;
        next_wr_reg_q = wr_reg_q;
        next_rd_drive_q = rd_drive_q;
        if (wr_fall) begin
            next_addr_q = addr;
            // A byte counts only if its request was up at the fall
            next_wr_dma_q = dma_cycle && (state == hpp_pkg::DMA_PLAY);
            next_wr_reg_q = reg_cycle;
        end
        if (rd_fall) begin
            // Bus owned only by cycles that return data
            next_rd_drive_q = reg_cycle || cap_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_q <= hpp_pkg::ADDR_INDEX;
            wr_data_q <= hpp_pkg::REG_RESET;
            wr_dma_q <= 1'b0;
            wr_reg_q <= 1'b0;
            rd_drive_q <= 1'b0;
        end else begin
            addr_q <= next_addr_q;
            wr_data_q <= data_in;
            wr_dma_q <= next_wr_dma_q;
            wr_reg_q <= next_wr_reg_q;
            rd_drive_q <= next_rd_drive_q;
        end
    end

    for (genvar i = 0; i < hpp_pkg::NUM_INDIRECT; i++) begin : g_ind
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                ind_regs[i] <= hpp_pkg::REG_RESET;
            end else if (wr_rise && wr_reg_q && addr_q == hpp_pkg::ADDR_IDATA
                         && index_reg[hpp_pkg::IDX_W-1:0] == (hpp_pkg::IDX_W)'(i)) begin
                ind_regs[i] <= next_ind_val;
            end
        end
    end

    // Request state: playback wins when both enabled, in single or dual mode
    always_comb begin
        next_state = state;
        unique case (state)
            hpp_pkg::DMA_IDLE: begin
                // Wait for a write in flight to land, so the FIFO count is current
                if (pen && play_in.ready && wr_n && wr_q) begin
                    next_state = hpp_pkg::DMA_PLAY;
                end else if (cen && cap_pending) begin
                    next_state = hpp_pkg::DMA_CAP;
                end
            end
            hpp_pkg::DMA_PLAY: if (play_last) begin
                next_state = hpp_pkg::DMA_IDLE;
            end
            hpp_pkg::DMA_CAP: if (cap_byte && cap_last) begin
                next_state = hpp_pkg::DMA_IDLE;
            end
            default: next_state = hpp_pkg::DMA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= hpp_pkg::DMA_IDLE;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            index_reg <= hpp_pkg::REG_RESET;
            data_q <= hpp_pkg::REG_RESET;
            play_hold <= '0;
            cap_word <= '0;
            cap_pending <= 1'b0;
            cap_idx <= hpp_pkg::BYTE_ZERO;
        end else begin
            state <= next_state;
            rd_q <= next_rd_q;
            wr_q <= next_wr_q;
            index_reg <= next_index_reg;
            data_q <= next_data_q;
            play_hold <= next_play_hold;
            cap_word <= next_cap_word;
            cap_pending <= next_cap_pending;
            cap_idx <= next_cap_idx;
        end
    end

    assign play_last = (state == hpp_pkg::DMA_PLAY) && wr_fall && dma_cycle
        && (asm_index + hpp_pkg::BYTE_STEP == bytes_per_sample);
    assign final_fall = play_last || (cap_byte && cap_last);
    assign play_req = (state == hpp_pkg::DMA_PLAY) || (state == hpp_pkg::DMA_CAP && single_mode);
    assign cap_req = (state == hpp_pkg::DMA_CAP) && !single_mode;
    // Drop at once on the final falling strobe, not a cycle later
    assign playback_dma_request = play_req && !final_fall;
    assign capture_dma_request = cap_req && !final_fall;
    // No hold-off output exists; data driven only while read held
    assign data_out = data_q;
    assign data_oe = !rd_n && !rd_q && rd_drive_q;
    assign playback_sample = play_hold;

    property p_req_held;
        @(posedge sys_clk) disable iff (!rst_n)
            (state == hpp_pkg::DMA_PLAY && !play_last) |=> state == hpp_pkg::DMA_PLAY;
    endproperty
    a_req_held: assert property (p_req_held) else $error("playback request ended early");
    property p_cap_low_sdc;
        @(posedge sys_clk) disable iff (!rst_n) single_mode |-> !capture_dma_request;
    endproperty
    a_cap_low_sdc: assert property (p_cap_low_sdc) else $error("capture request in single mode");
    property p_drop_now;
        @(posedge sys_clk) disable iff (!rst_n)
            final_fall |-> (!playback_dma_request && !capture_dma_request) ##1 (state == hpp_pkg::DMA_IDLE);
    endproperty
    a_drop_now: assert property (p_drop_now) else $error("request not dropped on last strobe");
    property p_no_reg_in_dma;
        @(posedge sys_clk) disable iff (!rst_n) (wr_rise && !wr_reg_q) |=> $stable(index_reg);
    endproperty
    a_no_reg_in_dma: assert property (p_no_reg_in_dma) else $error("DMA write reached registers");
    property p_oe_read;
        @(posedge sys_clk) disable iff (!rst_n) data_oe |-> !rd_n;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");
    property p_index_write;
        @(posedge sys_clk) disable iff (!rst_n)
            (wr_rise && wr_reg_q && addr_q == hpp_pkg::ADDR_INDEX) |=> index_reg == $past(wr_data_q);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index write lost");
    property p_hold_underrun;
        @(posedge sys_clk) disable iff (!rst_n) (sample_tick && !play_out.valid) |=> $stable(playback_sample);
    endproperty
    a_hold_underrun: assert property (p_hold_underrun) else $error("underrun changed output");
    property p_ack_is_dma;
        @(posedge sys_clk) disable iff (!rst_n) (rd_fall && dma_cycle && !cap_byte) |=> $stable(data_q);
    endproperty
    a_ack_is_dma: assert property (p_ack_is_dma) else $error("register cycle under acknowledge");
endmodule

// [include/hpp_pkg.sv]
package hpp_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SAMPLE_W = 32;
    // Direct register addresses
    localparam logic [1:0] ADDR_INDEX = 2'h0;
    localparam logic [1:0] ADDR_IDATA = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [1:0] ADDR_PIO_DATA = 2'h3;
    // Indirect register indices
    localparam logic [3:0] IDX_FORMAT = 4'h8;
    localparam logic [3:0] IDX_IFCFG = 4'h9;
    localparam int NUM_INDIRECT = 16;
    localparam int IDX_W = 4;
    // Format register fields
    localparam int FMT_STEREO_BIT = 4;
    localparam int FMT_LSB = 5;
    localparam int FMT_MSB = 6;
    localparam logic [1:0] FMT_LIN8 = 2'h0;
    localparam logic [1:0] FMT_ULAW = 2'h1;
    localparam logic [1:0] FMT_LIN16 = 2'h2;
    localparam logic [1:0] FMT_ALAW = 2'h3;
    // Interface configuration fields
    localparam int CFG_PEN_BIT = 0;
    localparam int CFG_CEN_BIT = 1;
    localparam int CFG_SDC_BIT = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_MAX = 3'h4;
    localparam logic [2:0] BYTE_ZERO = 3'h0;
    localparam logic [2:0] BYTE_STEP = 3'h1;
    localparam logic [4:0] SHIFT_BYTE = 5'h08;
    // Sample period in system clocks, kept small and fixed
    localparam int SAMPLE_PERIOD = 4166;
    localparam logic [12:0] SAMPLE_CNT_MAX = 13'(SAMPLE_PERIOD - 1);
    localparam logic [12:0] SAMPLE_CNT_ZERO = 13'h0000;
    typedef enum logic [1:0] {DMA_IDLE = 2'b00, DMA_PLAY = 2'b01, DMA_CAP = 2'b10} dma_state_t;
endpackage

// [include/hpp_stream_if.sv]
interface hpp_stream_if;
    logic valid;
    logic ready;
    logic [31:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// [hw/hpp_fifo.sv]
module hpp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Streams
    hpp_stream_if.snk in_s,
    hpp_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;
    assign in_s.ready = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;
    always_comb begin
        next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
        next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end
    property p_no_overflow;
        @(posedge sys_clk) disable iff (!rst_n) count <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule

// [hw/hpp_sample_asm.sv]
module hpp_sample_asm (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Byte side
    input wire logic byte_strobe,
    input wire logic [7:0] byte_in,
    input wire logic [2:0] bytes_per_sample,
    input wire logic abort,
    // Assembled sample
    output logic [31:0] sample,
    output logic sample_done,
    output logic [2:0] byte_index
);
    logic [2:0] next_byte_index;
    logic [31:0] next_sample;
    logic last;
    assign last = (byte_index + hpp_pkg::BYTE_STEP) == bytes_per_sample;
    assign sample_done = byte_strobe && last;
    always_comb begin
        next_byte_index = byte_index;
        next_sample = sample;
        if (abort) begin
            next_byte_index = hpp_pkg::BYTE_ZERO;
        end else if (byte_strobe) begin
            // Low byte first, left word before right
            next_sample[byte_index*hpp_pkg::SHIFT_BYTE +: 8] = byte_in;
            next_byte_index = last ? hpp_pkg::BYTE_ZERO : byte_index + hpp_pkg::BYTE_STEP;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            byte_index <= hpp_pkg::BYTE_ZERO;
            sample <= '0;
        end else begin
            byte_index <= next_byte_index;
            sample <= next_sample;
        end
    end
    property p_index_bound;
        @(posedge sys_clk) disable iff (!rst_n) byte_index < hpp_pkg::BYTES_MAX;
    endproperty
    a_index_bound: assert property (p_index_bound) else $error("byte index past sample size");
endmodule

// [testbench/host_bus_model.sv]
module host_bus_model (
    // Clock
    input wire logic sys_clk,
    // Host bus
    output logic chip_select_n,
    output logic rd_n,
    output logic wr_n,
    output logic [1:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    // DMA handshake
    input wire logic playback_dma_request,
    input wire logic capture_dma_request,
    output logic playback_dma_ack_n,
    output logic capture_dma_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 2'h0;
        data_in = 8'h00;
        playback_dma_ack_n = 1'b1;
        capture_dma_ack_n = 1'b1;
    end

    // Acks are {capture, playback}; select with no ack makes a register cycle
    task automatic cycle(input logic sel, input logic wr, input logic [1:0] a, input logic [7:0] d,
                         input logic [1:0] ack, output logic [7:0] q, output logic [1:0] req, output logic oe);
        @(negedge sys_clk);
        chip_select_n = ~sel;
        addr = a;
        data_in = wr ? d : ~data_in;
        {capture_dma_ack_n, playback_dma_ack_n} = ~ack;
        @(negedge sys_clk);
        wr_n = ~wr;
        rd_n = wr;
        @(negedge sys_clk);
        req = {playback_dma_request, capture_dma_request};
        @(negedge sys_clk);
        q = data_out;
        oe = data_oe;
        wr_n = 1'b1;
        rd_n = 1'b1;
        @(negedge sys_clk);
        // Select, ack and data outlive the strobe by one cycle
        chip_select_n = 1'b1;
        {capture_dma_ack_n, playback_dma_ack_n} = 2'b11;
        data_in = ~data_in;
    endtask
endmodule

// [testbench/audio_codec_parallel_host_port_test.sv]
module audio_codec_parallel_host_port_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_tick = 1'b0;
    logic [31:0] capture_sample = 32'h0000_0000;
    logic chip_select_n, rd_n, wr_n, data_oe;
    logic [1:0] addr;
    logic [7:0] data_in, data_out;
    logic playback_dma_request, capture_dma_request, playback_dma_ack_n, capture_dma_ack_n;
    logic [31:0] playback_sample;
    logic [7:0] q;
    logic [1:0] req;
    logic oe;
    int errors = 0;
    int compares = 0;

    always #2.5 sys_clk = ~sys_clk;

    hpp_host_port i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(chip_select_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .playback_dma_request(playback_dma_request), .capture_dma_request(capture_dma_request),
        .playback_dma_ack_n(playback_dma_ack_n), .capture_dma_ack_n(capture_dma_ack_n),
        .sample_tick(sample_tick), .capture_sample(capture_sample), .playback_sample(playback_sample)
    );

    host_bus_model i_host (
        .sys_clk(sys_clk), .chip_select_n(chip_select_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .playback_dma_request(playback_dma_request), .capture_dma_request(capture_dma_request),
        .playback_dma_ack_n(playback_dma_ack_n), .capture_dma_ack_n(capture_dma_ack_n)
    );

    task automatic give_verdict();
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic poll(input logic [1:0] exp, input int lim, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge sys_clk);
            hit = ({playback_dma_request, capture_dma_request} === exp);
        end
    endtask

    task automatic wait_req(input logic [1:0] exp);
        bit hit;
        poll(exp, 200, hit);
        if (!hit) begin
            errors++;
            $display("BAD request wait expected %h seen %h", exp, {playback_dma_request, capture_dma_request});
            give_verdict();
        end
    endtask

    task automatic reg_wr(input logic [3:0] idx, input logic [7:0] val);
        i_host.cycle(1'b1, 1'b1, hpp_pkg::ADDR_INDEX, 8'(idx), 2'b00, q, req, oe);
        i_host.cycle(1'b1, 1'b1, hpp_pkg::ADDR_IDATA, val, 2'b00, q, req, oe);
    endtask

    task automatic reg_rd(input logic [3:0] idx);
        i_host.cycle(1'b1, 1'b1, hpp_pkg::ADDR_INDEX, 8'(idx), 2'b00, q, req, oe);
        i_host.cycle(1'b1, 1'b0, hpp_pkg::ADDR_IDATA, 8'h00, 2'b00, q, req, oe);
    endtask

    // Margin for the registered converter output to settle
    task automatic tick();
        @(negedge sys_clk);
        sample_tick = 1'b1;
        @(negedge sys_clk);
        sample_tick = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic t_reset();
        check("requests after reset", {playback_dma_request, capture_dma_request}, 2'b00);
        check("data_oe after reset", data_oe, 1'b0);
    endtask

    task automatic t_regs();
        reg_wr(hpp_pkg::IDX_FORMAT, 8'h50);
        reg_wr(hpp_pkg::IDX_IFCFG, 8'h00);
        reg_rd(hpp_pkg::IDX_FORMAT);
        check("format readback", q, 8'h50);
        check("data_oe during read", oe, 1'b1);
        @(negedge sys_clk);
        check("data_oe after read", data_oe, 1'b0);
        reg_rd(hpp_pkg::IDX_IFCFG);
        check("config readback", q, 8'h00);
        // Acknowledged read with a stray select must leave the bus alone
        i_host.cycle(1'b1, 1'b0, hpp_pkg::ADDR_IDATA, 8'h00, 2'b01, q, req, oe);
        check("data_oe under acknowledge", oe, 1'b0);
    endtask

    task automatic t_play();
        logic [31:0] w;
        w = 32'h8877_6655;
        reg_wr(hpp_pkg::IDX_IFCFG, 8'h01);
        wait_req(2'b10);
        // Second byte carries a stray select aimed at the data register
        for (int b = 0; b < 4; b++) begin
            i_host.cycle(b == 1, 1'b1, hpp_pkg::ADDR_IDATA, w[8*b+:8], 2'b01, q, req, oe);
            check("playback request", req, (b == 3) ? 2'b00 : 2'b10);
        end
        reg_rd(hpp_pkg::IDX_IFCFG);
        check("config after dma", q, 8'h01);
        tick();
        check("played word", playback_sample, w);
        tick();
        check("held word on underrun", playback_sample, w);
    endtask

    task automatic t_formats();
        logic [1:0] fm [4] = '{hpp_pkg::FMT_LIN8, hpp_pkg::FMT_ULAW, hpp_pkg::FMT_LIN16, hpp_pkg::FMT_ALAW};
        int n [4] = '{1, 1, 2, 2};
        logic st [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        for (int f = 0; f < 4; f++) begin
            reg_wr(hpp_pkg::IDX_FORMAT, {1'b0, fm[f], st[f], 4'h0});
            wait_req(2'b10);
            for (int b = 0; b < n[f]; b++) begin
                i_host.cycle(1'b0, 1'b1, 2'h0, 8'(f + b), 2'b01, q, req, oe);
                check("bytes per sample", req, (b == n[f] - 1) ? 2'b00 : 2'b10);
            end
        end
    endtask

    task automatic t_fill();
        int k;
        bit hit;
        k = 0;
        reg_wr(hpp_pkg::IDX_FORMAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            poll(2'b10, 60, hit);
            if (hit) begin
                i_host.cycle(1'b0, 1'b1, 2'h0, 8'(i), 2'b01, q, req, oe);
                k++;
            end
        end
        check("samples until full", k, hpp_pkg::FIFO_DEPTH - 4);
        tick();
        poll(2'b10, 60, hit);
        check("request after drain", hit, 1'b1);
        // A raised request is still served after playback is disabled
        reg_wr(hpp_pkg::IDX_IFCFG, 8'h00);
        i_host.cycle(1'b0, 1'b1, 2'h0, 8'h09, 2'b01, q, req, oe);
        check("request after final sample", req, 2'b00);
        poll(2'b10, 20, hit);
        check("request once disabled", hit, 1'b0);
    endtask

    task automatic t_cap(input bit single);
        logic [31:0] w;
        logic [1:0] ack;
        logic [1:0] exp;
        w = single ? 32'h1F2E_3D4C : 32'hA1B2_C3D4;
        ack = single ? 2'b01 : 2'b10;
        exp = single ? 2'b10 : 2'b01;
        reg_wr(hpp_pkg::IDX_FORMAT, 8'h50);
        reg_wr(hpp_pkg::IDX_IFCFG, {5'h00, single, 2'b10});
        capture_sample = w;
        tick();
        wait_req(exp);
        for (int b = 0; b < 4; b++) begin
            i_host.cycle(1'b0, 1'b0, 2'h0, 8'h00, ack, q, req, oe);
            check("capture byte", q, w[8*b+:8]);
            check("capture request", req, (b == 3) ? 2'b00 : exp);
        end
    endtask

    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_regs();
        t_play();
        t_formats();
        t_fill();
        t_cap(1'b0);
        t_cap(1'b1);
        give_verdict();
    end
endmodule
